// *** bench/idio_far_end.sv ***
// Far-side equipment model: resolves each pin wire
`timescale 1ns/100ps
`default_nettype none
module idio_far_end (
    // Port drive from the instrument
    input  wire logic [6:0] o_pin,
    input  wire logic [6:0] o_pin_oe_b,
    // Level the equipment applies, idle high, pulses go low; inhibit bit 4 idles low
    input  wire logic [6:0] i_drv_lvl,
    // Resolved wire
    output wire logic [6:0] o_wire
);
    // Port wins where it drives, equipment elsewhere
    assign o_wire = (o_pin & ~o_pin_oe_b) | (i_drv_lvl & o_pin_oe_b);
endmodule // idio_far_end
`default_nettype wire

// *** bench/idio_port_checker.sv ***
// Checker of port pin levels, pulses and events
`timescale 1ns/100ps
`default_nettype none
module idio_port_checker (
    // Port signals as seen at the block
    input wire logic                    i_clk,
    input wire logic                    i_rst_b,
    input wire logic                    i_cfg_load,
    input wire idio_pkg::idio_stat_type i_stat,
    input wire logic [6:0]              i_pin,
    input wire logic [6:0]              o_pin,
    input wire logic [6:0]              o_pin_oe_b,
    input wire idio_pkg::idio_evt_type  o_evt
);
    import idio_pkg::*;
    logic        dflt;
    logic [12:0] low_cnt;
    // Default-config flag and pin 1 low-time counter
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            dflt    <= 1'b1;
            low_cnt <= 13'h0;
        end else begin
            dflt    <= dflt && !i_cfg_load;
            low_cnt <= (!o_pin[0] && !o_pin_oe_b[0]) ? low_cnt + 13'h1 : 13'h0;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    sequence s_turn_on; dflt && $rose(i_stat.output_on) && !i_stat.protection; endsequence
    sequence s_pin1_low; !o_pin[0] && !o_pin_oe_b[0]; endsequence
    property p_prot_ind; (dflt && i_stat.protection)[*3] |-> !o_pin[1] && !o_pin_oe_b[1]; endproperty
    property p_off_ind; (dflt && !i_stat.output_on)[*3] |-> o_pin[2] && !o_pin_oe_b[2]; endproperty
    property p_on_pulse; s_turn_on |-> ##[1:3] s_pin1_low; endproperty
    property p_pulse_len; dflt && $rose(o_pin[0]) |-> low_cnt == 13'(PULSE_CYCLES); endproperty
    property p_sync_on; dflt && i_stat.sync_on_req |-> ##[1:3] !o_pin[5] && !o_pin_oe_b[5]; endproperty
    property p_sync_off; dflt && i_stat.sync_off_req |-> ##[1:3] !o_pin[6] && !o_pin_oe_b[6]; endproperty
    property p_clear; o_evt.prot_clear |-> $past(i_stat.protection); endproperty
    property p_trig; o_evt.trigger |-> $past(i_stat.ext_trig_sel) ##1 !o_evt.trigger; endproperty
    property p_inhibit; (dflt && i_pin[4])[*6] |-> o_evt.inhibit; endproperty
    a_prot_ind: assert property (p_prot_ind) else $error("protection pin level wrong");
    a_off_ind: assert property (p_off_ind) else $error("status pin level wrong");
    a_on_pulse: assert property (p_on_pulse) else $error("no pulse on turn-on");
    a_pulse_len: assert property (p_pulse_len) else $error("pulse width wrong");
    a_sync_on: assert property (p_sync_on) else $error("no sync-on pulse");
    a_sync_off: assert property (p_sync_off) else $error("no sync-off pulse");
    a_clear: assert property (p_clear) else $error("clear without protection");
    a_trig: assert property (p_trig) else $error("bad trigger event");
    a_inhibit: assert property (p_inhibit) else $error("inhibit not raised");
endmodule // idio_port_checker
bind idio_port idio_port_checker chk_u (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_cfg_load(i_cfg_load), .i_stat(i_stat), .i_pin(i_pin), .o_pin(o_pin),
    .o_pin_oe_b(o_pin_oe_b), .o_evt(o_evt));
`default_nettype wire

// *** bench/test_idio_port.sv ***
// Self-checking testbench of the digital I/O port
`timescale 1ns/100ps
`default_nettype none
module test_idio_port;
    import idio_pkg::*;
    logic          i_clk = 1'b0;
    logic          i_rst_b = 1'b0;
    logic          i_cfg_load = 1'b0;
    idio_cfg_type  i_cfg [NUM_PINS];
    idio_stat_type i_stat = '0;
    logic [6:0]    pin_w, o_pin, oe_b, in_lvl;
    logic [6:0]    drv_lvl = 7'h6F;
    idio_evt_type  evt, seen;
    int            miscompares = 0;
    int            tests_run = 0;
    int            n;
    always #5 i_clk = ~i_clk;
    idio_port dut_u (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_cfg(i_cfg),
        .i_cfg_load(i_cfg_load), .i_stat(i_stat), .i_pin(pin_w), .o_pin(o_pin),
        .o_pin_oe_b(oe_b), .o_in_level(in_lvl), .o_evt(evt));
    idio_far_end far_u (.o_pin(o_pin), .o_pin_oe_b(oe_b), .i_drv_lvl(drv_lvl),
        .o_wire(pin_w));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task tick(input int k); repeat (k) @(negedge i_clk); endtask
    task check(input string name, input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Low pulse of k cycles on pin p, gathering events
    task pulse_in(input int p, input int k);
        seen = '0;
        drv_lvl[p] = 1'b0;
        repeat (k + 8) begin
            tick(1);
            seen = seen | evt;
            if (k-- == 1) drv_lvl[p] = 1'b1;
        end
    endtask
    // Count driven-low cycles on pin p over one pulse span
    task measure(input int p);
        n = 0;
        seen = '0;
        repeat (PULSE_CYCLES + 100) begin
            tick(1);
            seen = seen | evt;
            n += int'(o_pin[p] === 1'b0 && oe_b[p] === 1'b0);
        end
    endtask
    task set_all(input idio_mode_type m, input logic inv, input logic t);
        foreach (i_cfg[p]) i_cfg[p] = '{m, inv, t, 24'h00000A, 24'h000003};
        i_cfg_load = 1'b1;
        tick(1);
        i_cfg_load = 1'b0;
        tick(4);
    endtask
    task give_verdict;
        $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        foreach (i_cfg[p]) i_cfg[p] = '0;
        tick(4);
        check("rst pin", o_pin, 7'h7F);
        check("rst oe", oe_b, 7'h7F);
        i_rst_b = 1'b1;
        i_stat.protection = 1'b1;
        tick(4);
        check("prot low", o_pin[1], 1'b0);
        i_stat.protection = 1'b0;
        tick(4);
        check("prot high", o_pin[1], 1'b1);
        i_stat.output_on = 1'b1;
        measure(0);
        check("on pulse", n, PULSE_CYCLES[15:0]);
        check("on level", o_pin[2], 1'b0);
        i_stat.output_on = 1'b0;
        i_stat.protection = 1'b1;
        pulse_in(0, PULSE_CYCLES - 1);
        check("short clr", seen.prot_clear, 1'b0);
        pulse_in(0, PULSE_CYCLES);
        check("clear", seen.prot_clear, 1'b1);
        i_stat.protection = 1'b0;
        pulse_in(0, PULSE_CYCLES);
        check("no clear", seen.prot_clear, 1'b0);
        for (int s = 0; s < 2; s++) begin
            i_stat.ext_trig_sel = s[0];
            pulse_in(3, PULSE_CYCLES);
            check("trigger", seen.trigger, s[0]);
        end
        pulse_in(5, PULSE_CYCLES);
        check("sync on in", seen.sync_on, 1'b1);
        pulse_in(6, PULSE_CYCLES);
        check("sync off in", seen.sync_off, 1'b1);
        for (int p = 5; p < 7; p++) begin
            i_stat.sync_on_req = (p == 5);
            i_stat.sync_off_req = (p == 6);
            tick(1);
            i_stat.sync_on_req = 1'b0;
            i_stat.sync_off_req = 1'b0;
            measure(p);
            check("sync out", n, PULSE_CYCLES[15:0]);
            check("own pulse", seen.sync_on | seen.sync_off, 1'b0);
        end
        check("no inhibit", evt.inhibit, 1'b0);
        drv_lvl[4] = 1'b1;
        tick(8);
        check("inhibit", evt.inhibit, 1'b1);
        set_all(IDIO_MODE_DEFAULT, 1'b1, 1'b0);
        drv_lvl[4] = 1'b0;
        tick(8);
        check("inv inhibit", evt.inhibit, 1'b1);
        set_all(IDIO_MODE_OUTPUT, 1'b0, 1'b1);
        check("out true", o_pin, 7'h00);
        check("out oe", oe_b, 7'h00);
        set_all(IDIO_MODE_OUTPUT, 1'b0, 1'b0);
        check("out false", o_pin, 7'h7F);
        set_all(IDIO_MODE_OUTPUT, 1'b1, 1'b1);
        check("out inv", o_pin, 7'h7F);
        set_all(IDIO_MODE_INPUT, 1'b0, 1'b0);
        drv_lvl = 7'h55;
        tick(4);
        check("in level", in_lvl, 7'h2A);
        check("in oe", oe_b, 7'h7F);
        set_all(IDIO_MODE_PWM, 1'b0, 1'b0);
        n = 0;
        repeat (100) begin
            tick(1);
            n += $countones(~o_pin);
        end
        check("pwm lows", n, 16'h00D2);
        give_verdict();
    end
    // Watchdog
    initial begin
        repeat (60000) @(posedge i_clk);
        miscompares++;
        give_verdict();
    end
endmodule // test_idio_port
`default_nettype wire

// *** shared/idio_pkg.sv ***
// Package for the instrument digital I/O port: modes, timing, carriers
`default_nettype none
package idio_pkg;
    localparam int NUM_PINS = 7;
    // Pin modes
    typedef enum logic [1:0] {
        IDIO_MODE_DEFAULT = 2'h0,
        IDIO_MODE_INPUT   = 2'h1,
        IDIO_MODE_OUTPUT  = 2'h2,
        IDIO_MODE_PWM     = 2'h3
    } idio_mode_type;
    localparam idio_mode_type RESET_MODE   = IDIO_MODE_DEFAULT;
    localparam logic          RESET_INVERT = 1'b0;
    // Pin numbers (zero based) of default functions
    localparam int PIN_PROT_CLEAR = 0;
    localparam int PIN_PROT_IND   = 1;
    localparam int PIN_ONOFF_IND  = 2;
    localparam int PIN_TRIGGER    = 3;
    localparam int PIN_INHIBIT    = 4;
    localparam int PIN_SYNC_ON    = 5;
    localparam int PIN_SYNC_OFF   = 6;
    // Timing
    localparam int CLK_PERIOD_NS  = 10;
    localparam int PULSE_MIN_US   = 30;
    localparam int PULSE_CYCLES   =
        (PULSE_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W          = 12;
    localparam int PWM_W          = 24;
    // Per-pin configuration
    typedef struct packed {
        idio_mode_type      mode;
        logic               invert;
        logic               out_true;
        logic [PWM_W-1:0]   pwm_period;
        logic [PWM_W-1:0]   pwm_low;
    } idio_cfg_type;
    // Instrument status fed to the port
    typedef struct packed {
        logic protection;
        logic output_on;
        logic ext_trig_sel;
        logic sync_on_req;
        logic sync_off_req;
    } idio_stat_type;
    // Events and levels sent to the instrument
    typedef struct packed {
        logic prot_clear;
        logic trigger;
        logic inhibit;
        logic sync_on;
        logic sync_off;
    } idio_evt_type;
endpackage
`default_nettype wire

// *** verilog/idio_port.sv ***
// Seven-pin configurable digital I/O port of the instrument
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Each pin selects default, input, output or PWM
// - All pins share identical general I/O logic
// - Pulses are active low, falling edge first
// - Pulses stay low at least 30 us
// - Output true drives low, false drives high
// - Input mode samples and reports pin level
// - PWM uses per-pin period and duty settings
// - Duty sets low fraction of each period
// - Normal polarity keeps default active level
// - Invert complements level for input and output
// - Inhibit pin active high disables output
// - Pin 1 pulse clears active protection
// - Pin 1 pulses when output turns on without protection
// - Pin 2 reflects protection state
// - Pin 6 pulse switches linked outputs on
// - Pin 7 pulse switches linked outputs off
// - Pin 5 turns output off in emergency
// - Protection pin high when free, low protected
// - Status pin high off, low on
// - Pin 4 pulse triggers when external selected
module idio_port (
    // Clock and reset
    input  wire logic                   i_clk,
    input  wire logic                   i_rst_b,
    // Configuration per pin
    input  wire idio_pkg::idio_cfg_type i_cfg [idio_pkg::NUM_PINS],
    input  wire logic                   i_cfg_load,
    // Instrument status
    input  wire idio_pkg::idio_stat_type i_stat,
    // Pins
    input  wire logic [6:0]             i_pin,
    output var  logic [6:0]             o_pin,
    output var  logic [6:0]             o_pin_oe_b,
    // Results to the instrument
    output var  logic [6:0]             o_in_level,
    output var  idio_pkg::idio_evt_type o_evt
);
    import idio_pkg::*;

    //------------------------------------------------------------------
    // Configuration storage
    //------------------------------------------------------------------
    // Stored configuration
    idio_cfg_type  cfg [NUM_PINS];
    // Turn-on edge detection
    logic          prev_on;
    logic          next_prev_on;
    logic          on_edge;
    logic          on_rise;
    // Per-pin vectors between stages
    logic [6:0]    pulse_req;
    logic [6:0]    in_valid;
    logic [6:0]    in_active;
    logic [6:0]    drive_level;
    logic [6:0]    drive_en;

    // Whole table copied on each clock while load is high
    // Latch configuration; reset gives default function, normal
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int k = 0; k < NUM_PINS; k++) begin
                cfg[k] <= '0;
            end
        end else if (i_cfg_load) begin
            cfg <= i_cfg;
        end
    end

    //------------------------------------------------------------------
    // Status edge and pulse requests
    //------------------------------------------------------------------
    // Output turn-on edge detect
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            prev_on <= 1'b0;
        end else begin
            prev_on <= next_prev_on;
        end
    end
    assign next_prev_on = i_stat.output_on;
    assign on_edge      = i_stat.output_on & ~prev_on;
    // Turn-on pulse only when protection is clear at the turn-on edge
    assign on_rise      = on_edge & ~i_stat.protection;

    // Which default-function pins emit a pulse this cycle
    assign pulse_req[PIN_PROT_CLEAR] = on_rise;
    // Level pins and input pins never request a pulse
    assign pulse_req[PIN_PROT_IND]   = 1'b0;
    assign pulse_req[PIN_ONOFF_IND]  = 1'b0;
    assign pulse_req[PIN_TRIGGER]    = 1'b0;
    assign pulse_req[PIN_INHIBIT]    = 1'b0;
    assign pulse_req[PIN_SYNC_ON]    = i_stat.sync_on_req;
    assign pulse_req[PIN_SYNC_OFF]   = i_stat.sync_off_req;

    //------------------------------------------------------------------
    // Per-pin logic, identical for every pin except the default-function drive
    //------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : g_pin
            // Low-width counter runs on the synchronised level after polarity, in every mode
            // Input side
            logic             sync1;
            logic             sync2;
            logic             next_sync2;
            logic             lvl;
            logic [CNT_W-1:0] low_cnt;
            logic [CNT_W-1:0] next_low_cnt;
            logic             taken;
            logic             next_taken;
            logic             fire;
            logic             low_full;
            logic             low_last;
            logic             own_busy;
            logic             next_own_busy;

            // Output side
            logic [CNT_W-1:0] out_cnt;
            logic [CNT_W-1:0] next_out_cnt;
            logic             req_load;
            logic             out_busy;
            logic [PWM_W-1:0] pwm_cnt;
            logic [PWM_W-1:0] next_pwm_cnt;
            logic [PWM_W-1:0] pwm_step;
            logic             pwm_wrap;
            logic             pwm_low;
            logic             pulse_low;

            // Drive selection
            logic             dflt_low;
            logic             dflt_out;
            logic             act_low;
            logic             drv;
            logic             en;

            // Mode decode
            idio_mode_type    md;
            logic             is_dflt;
            logic             is_out;
            logic             is_pwm;

            //----------------------------------------------------------
            // Mode decode
            //----------------------------------------------------------
            assign md = cfg[g].mode;

            // One wire per mode that matters here
            assign is_dflt = (md == IDIO_MODE_DEFAULT);
            assign is_out  = (md == IDIO_MODE_OUTPUT);
            assign is_pwm  = (md == IDIO_MODE_PWM);

            //----------------------------------------------------------
            // Input qualification
            //----------------------------------------------------------
            // Two-stage synchroniser
            always_ff @(posedge i_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    sync1 <= 1'b1;
                    sync2 <= 1'b1;
                end else begin
                    sync1 <= i_pin[g];
                    sync2 <= next_sync2;
                end
            end
            assign next_sync2 = sync1;

            // Level after polarity; active when low in normal polarity
            assign lvl = sync2 ^ cfg[g].invert;
            // One bit per pin for the instrument
            assign in_active[g] = ~lvl;

            // Counter saturates once the full width is seen
            assign low_full = (low_cnt == CNT_W'(PULSE_CYCLES));
            // Last sample that completes the minimum width
            assign low_last = (low_cnt == CNT_W'(PULSE_CYCLES - 1));

            // Low-width counter qualifies an input pulse
            assign next_low_cnt = lvl ? '0 :
                low_full ? low_cnt :
                low_cnt + CNT_W'(1);
            always_ff @(posedge i_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    low_cnt <= '0;
                end else begin
                    low_cnt <= next_low_cnt;
                end
            end

            // Falling edge first, then the width, then one event
            assign fire = low_last & ~lvl & ~taken;
            // Rearms when the wire goes inactive
            assign next_taken = lvl ? 1'b0 : (taken | fire);
            always_ff @(posedge i_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    taken <= 1'b0;
                end else begin
                    taken <= next_taken;
                end
            end

            //----------------------------------------------------------
            // Own-drive memory
            //----------------------------------------------------------
            // Set while this pin drives, cleared once inactive again
            assign next_own_busy = drive_en[g] ? 1'b1 :
                lvl ? 1'b0 : own_busy;
            always_ff @(posedge i_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    own_busy <= 1'b0;
                end else begin
                    own_busy <= next_own_busy;
                end
            end

            // Pulse events only in default mode, never from own drive
            assign in_valid[g] = fire & ~drive_en[g] & ~own_busy &
                is_dflt;

            //----------------------------------------------------------
            // Output pulse and PWM
            //----------------------------------------------------------
            // A request in default mode reloads the full width
            assign req_load = pulse_req[g] & is_dflt;
            // Stretcher still counting down
            assign out_busy = (out_cnt != '0);

            // Output pulse stretcher, low for the full width
            assign next_out_cnt = req_load ? CNT_W'(PULSE_CYCLES) :
                out_busy ? out_cnt - CNT_W'(1) : out_cnt;
            assign pulse_low = out_busy;
            always_ff @(posedge i_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    out_cnt <= '0;
                end else begin
                    out_cnt <= next_out_cnt;
                end
            end

            // Next PWM count and end of period
            assign pwm_step = pwm_cnt + PWM_W'(1);
            assign pwm_wrap = (pwm_step >= cfg[g].pwm_period);

            // PWM counter: low for the first pwm_low cycles
            assign next_pwm_cnt = (~is_pwm | pwm_wrap) ? '0 :
                pwm_step;
            assign pwm_low = (pwm_cnt < cfg[g].pwm_low);
            always_ff @(posedge i_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    pwm_cnt <= '0;
                end else begin
                    pwm_cnt <= next_pwm_cnt;
                end
            end

            //----------------------------------------------------------
            // Pin drive
            //----------------------------------------------------------
            // Default-function drive: level pins and pulse pins
            if (g == PIN_PROT_IND) begin : g_prot
                assign dflt_out = 1'b1;
                assign dflt_low = i_stat.protection;
            end else if (g == PIN_ONOFF_IND) begin : g_onoff
                assign dflt_out = 1'b1;
                assign dflt_low = i_stat.output_on;
            end else if (g == PIN_PROT_CLEAR || g == PIN_SYNC_ON ||
                         g == PIN_SYNC_OFF) begin : g_pulse
                assign dflt_out = pulse_low;
                assign dflt_low = pulse_low;
            end else begin : g_in
                assign dflt_out = 1'b0;
                assign dflt_low = 1'b0;
            end

            // Mode selection of the active-low request
            assign act_low = is_out ? cfg[g].out_true :
                is_pwm ? pwm_low : dflt_low;
            // Input mode never drives the wire
            assign en = is_out | is_pwm | (is_dflt & dflt_out);
            // Polarity applied last, on the wire level
            assign drv = ~act_low ^ cfg[g].invert;
            // Handed to the registered outputs
            assign drive_level[g] = drv;
            assign drive_en[g]    = en;
        end
    endgenerate

    //------------------------------------------------------------------
    // Event assembly
    //------------------------------------------------------------------
    idio_evt_type  next_evt;

    // Clear and trigger events gated by instrument state; sync events are not
    assign next_evt.prot_clear = in_valid[PIN_PROT_CLEAR] &
        i_stat.protection;
    assign next_evt.trigger    = in_valid[PIN_TRIGGER] &
        i_stat.ext_trig_sel;
    // Inhibit is a level: high in normal polarity
    assign next_evt.inhibit    = ~in_active[PIN_INHIBIT] &
        (cfg[PIN_INHIBIT].mode == IDIO_MODE_DEFAULT);
    assign next_evt.sync_on    = in_valid[PIN_SYNC_ON];
    assign next_evt.sync_off   = in_valid[PIN_SYNC_OFF];

    //------------------------------------------------------------------
    // Registered outputs
    //------------------------------------------------------------------
    // Pin drive and enable
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_pin      <= 7'h7F;
            o_pin_oe_b <= 7'h7F;
        end else begin
            o_pin      <= drive_level;
            o_pin_oe_b <= ~drive_en;
        end
    end

    // Input levels and events
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_in_level <= 7'h00;
            o_evt      <= '0;
        end else begin
            o_in_level <= in_active;
            o_evt      <= next_evt;
        end
    end

endmodule // idio_port
`default_nettype wire
